// ===== hw/dio_point.sv
// configurable digital i/o point with time-proportioned output
// assumes synchronous field input and a one-cycle line_cycle pulse per ac cycle
//
// What this block does
// R01 - direction selects dry contact, voltage, or output
// R02 - input mode: transmitted signal follows field input
// R03 - off or zero demand holds output off
// R04 - on or full demand holds output on
// R05 - intermediate demand: on-time fraction matches percentage
// R06 - fixed base: on for fraction, then off
// R07 - fixed period 0.1 to 60 s
// R08 - variable base: whole line cycles, three minimum
// R09 - half: 3 on 3 off; two-thirds: 6/3
// R10 - low limit is power at zero demand
// R11 - high limit is power at full demand
// R12 - demand maps linearly between the limits
// R13 - changes apply next period; output starts off
`timescale 1ns/1ns
`include "dio_params.svh"
module dio_point
    import dio_pkg::*;
#(
    parameter int TENTH_CYCLES = `DIO_TENTH_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic [1:0]  direction,
    input  wire logic        contact_closed,
    input  wire logic        voltage_present,
    input  wire dio_demand_s demand,
    input  wire logic        demand_is_digital,
    input  wire dio_scale_s  limits,
    input  wire dio_tb_e     time_base,
    input  wire logic [9:0]  fixed_period,
    input  wire logic        line_cycle,
    output logic             function_block,
    output logic             field_out,
    output logic             field_out_en,
    output dio_pct_t         applied_power
);
    typedef struct packed {
        logic        xmit;
        logic        out;
        logic        drive;
        dio_tb_e     tb;
        logic [9:0]  period;
        logic [9:0]  on_len;
        logic [9:0]  pos;
        dio_pct_t    power;
        logic        force_on;
        logic        force_off;
        logic [15:0] acc;
        logic [1:0]  slot;
    } dio_state_s;
    dio_state_s state;
    dio_state_s next_state;
    dio_pct_t   scaled;
    logic       tick;
    logic [9:0] per;
    logic [19:0] on_prod;
    logic       is_out;
    logic       want_off;
    logic       want_on;
    logic       period_end;
    logic [15:0] acc_sum;

    dio_scale u_scale (
        .ref_clk (ref_clk),
        .reset   (reset),
        .demand  (demand),
        .limits  (limits),
        .power   (scaled)
    );

    dio_tick #(
        .TENTH_CYCLES (TENTH_CYCLES)
    ) u_tick (
        .ref_clk (ref_clk),
        .reset   (reset),
        .tick    (tick)
    );

    // direction decode and demand classification
    always_comb begin
        is_out = (direction == `DIO_DIR_OUT); // R01
        want_off = demand_is_digital ? !demand.on : (demand.pct == 10'h000); // R03
        want_on = demand_is_digital ? demand.on : (demand.pct >= `DIO_PCT_FULL); // R04
        per = fixed_period; // R07
        if (per < `DIO_PERIOD_MIN)
            per = `DIO_PERIOD_MIN;
        else if (per > `DIO_PERIOD_MAX)
            per = `DIO_PERIOD_MAX;
        on_prod = scaled * per;
        // a latched period of zero, as after reset, ends on the first tick;
        // otherwise period - 1 wraps to 1023 and the first period would last 1024 ticks
        if (state.tb == DIO_TB_FIXED)
            period_end = tick && ((state.period == 10'h000) ||
                                  (state.pos >= state.period - 10'd1));
        else
            period_end = line_cycle && (state.slot == `DIO_VTB_SLOT - 2'd1);
        acc_sum = state.acc + 16'(state.power);
    end

    // sequencer: latches settings at period boundaries so a change never
    // chops a running on-interval; inputs of the point bypass it entirely
    always_comb begin
        next_state = state;
        next_state.drive = is_out; // R01
        if (direction == `DIO_DIR_DRY)
            next_state.xmit = contact_closed; // R02
        else if (direction == `DIO_DIR_VOLT)
            next_state.xmit = voltage_present; // R02
        else
            next_state.xmit = 1'b0;
        if (!is_out) begin
            next_state.out = 1'b0;
            next_state.pos = '0;
            next_state.slot = '0;
            next_state.acc = '0;
        end else begin
            if (state.tb == DIO_TB_FIXED) begin
                if (tick)
                    next_state.pos = period_end ? 10'h000 : state.pos + 10'd1; // R06
            end else if (line_cycle) begin
                next_state.slot = period_end ? 2'd0 : state.slot + 2'd1; // R08
            end
            if (period_end) begin
                // new period: take the latest settings
                next_state.tb = time_base; // R13
                next_state.period = per; // R07
                next_state.on_len = 10'(on_prod / 20'd1000); // R06
                next_state.power = scaled;
                next_state.force_off = want_off;
                next_state.force_on = want_on;
                // variable base: accumulate power, one 3-cycle slot each decision
                if (state.tb == DIO_TB_VARIABLE) begin
                    if (acc_sum >= 16'(`DIO_PCT_FULL)) begin
                        next_state.acc = acc_sum - 16'(`DIO_PCT_FULL);
                        next_state.out = 1'b1; // R09
                    end else begin
                        next_state.acc = acc_sum;
                        next_state.out = 1'b0; // R09
                    end
                end
            end
            // the first slot of a new period already obeys the new forcing and on_len; a variable-base slot is still decided from the previous power
            if (next_state.force_off)
                next_state.out = 1'b0; // R03
            else if (next_state.force_on)
                next_state.out = 1'b1; // R04
            else if (state.tb == DIO_TB_FIXED)
                next_state.out = (next_state.pos < next_state.on_len); // R05
            if (period_end && want_off)
                next_state.out = 1'b0;
        end
    end

    // state starts with the output off and a period of zero
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= '0; // R13
        end else begin
            state <= next_state;
        end
    end

    assign function_block = state.xmit;
    assign field_out = state.out;
    assign field_out_en = state.drive;
    assign applied_power = state.power;
endmodule

// ===== hw/dio_params.svh
// constants for the digital i/o time-proportioning point
// assumes a 100 MHz ref_clk and a line-cycle pulse from the mains detector
`ifndef DIO_PARAMS_SVH
`define DIO_PARAMS_SVH
`define DIO_CLK_HZ          100000000
`define DIO_TENTH_S_NS      100000000
`define DIO_CLK_PERIOD_NS   10
`define DIO_TENTH_CYCLES    (`DIO_TENTH_S_NS / `DIO_CLK_PERIOD_NS)
`define DIO_PERIOD_MIN      10'd1
`define DIO_PERIOD_MAX      10'd600
`define DIO_PCT_FULL        10'd1000
`define DIO_VTB_SLOT        2'd3
`define DIO_DIR_DRY         2'd0
`define DIO_DIR_VOLT        2'd1
`define DIO_DIR_OUT         2'd2
`endif

// ===== hw/dio_pkg.sv
// types shared by the digital i/o point and its helpers
// assumes dio_params.svh supplies the numeric constants
package dio_pkg;
    typedef logic [9:0] dio_pct_t;
    typedef enum logic {DIO_TB_FIXED, DIO_TB_VARIABLE} dio_tb_e;
    typedef struct packed {
        logic     on;
        dio_pct_t pct;
    } dio_demand_s;
    typedef struct packed {
        dio_pct_t low;
        dio_pct_t high;
    } dio_scale_s;
endpackage

// ===== hw/dio_scale.sv
// linear map of demand between low and high power limits
// assumes demand, limits in tenth-percent, 0..1000
`timescale 1ns/1ns
`include "dio_params.svh"
module dio_scale
    import dio_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire dio_demand_s demand,
    input  wire dio_scale_s  limits,
    output dio_pct_t         power
);
    typedef struct packed {
        dio_pct_t power;
    } dio_sc_state_s;
    dio_sc_state_s state;
    dio_sc_state_s next_state;
    logic signed [21:0] span;
    logic signed [21:0] prod;
    logic signed [21:0] res;
    // power = low + (high - low) * pct / 1000, clamped
    always_comb begin
        next_state = state;
        span = 22'(signed'({1'b0, limits.high})) - 22'(signed'({1'b0, limits.low}));
        prod = span * 22'(signed'({1'b0, demand.pct}));
        res = 22'(signed'({1'b0, limits.low})) + prod / 22'sd1000; // R12
        if (demand.pct == 10'h000)
            res = 22'(signed'({1'b0, limits.low})); // R10
        else if (demand.pct >= `DIO_PCT_FULL)
            res = 22'(signed'({1'b0, limits.high})); // R11
        if (res < 22'sd0)
            res = 22'sd0;
        else if (res > 22'sd1000)
            res = 22'sd1000;
        next_state.power = res[9:0];
    end
    // registered so the product stays off the switching path
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
    assign power = state.power;
endmodule

// ===== hw/dio_tick.sv
// divider producing a one-cycle pulse every tenth of a second
// assumes ref_clk at the rate in dio_params.svh
`timescale 1ns/1ns
`include "dio_params.svh"
module dio_tick
    import dio_pkg::*;
#(
    parameter int TENTH_CYCLES = `DIO_TENTH_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic reset,
    output logic      tick
);
    typedef struct packed {
        logic [23:0] cnt;
        logic        tick;
    } dio_tk_state_s;
    dio_tk_state_s state;
    dio_tk_state_s next_state;
    // wrap counter; tick is registered for clean timing
    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (state.cnt >= 24'(TENTH_CYCLES - 1)) begin
            next_state.cnt = '0;
            next_state.tick = 1'b1;
        end else begin
            next_state.cnt = state.cnt + 24'h000001;
        end
    end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
    assign tick = state.tick;
endmodule

// ===== verif/dio_point_asserts.sv
// port checker for the digital i/o point
// assumes it is bound into every dio_point instance
`timescale 1ns/1ns
module dio_point_asserts
    import dio_pkg::*;
#(
    parameter int TENTH_CYCLES = 20
) (
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic [1:0] direction,
    input wire logic       contact_closed,
    input wire logic       voltage_present,
    input wire logic       function_block,
    input wire logic       field_out,
    input wire logic       field_out_en,
    input wire dio_pct_t   applied_power
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    out_en_a: assert property (direction == 2'h2 |=> field_out_en)
        else $error("drive enable low in output mode");
    in_en_a: assert property (direction != 2'h2 |=> !field_out_en)
        else $error("drive enable high in input mode");
    dry_in_a: assert property (direction == 2'h0 |=>
        function_block == $past(contact_closed)) else $error("contact not transmitted");
    volt_in_a: assert property (direction == 2'h1 |=>
        function_block == $past(voltage_present)) else $error("voltage not transmitted");
    quiet_a: assert property (direction[1] |=> !function_block)
        else $error("transmit active outside input modes");
    reset_off_a: assert property ($past(reset) |-> !field_out && applied_power == 10'h000)
        else $error("output not off after reset");
    hold_a: assert property ($changed(field_out) |=>
        ($stable(field_out) || direction != 2'h2)[*8]) else $error("output switched too soon");
    power_a: assert property (applied_power <= 10'h3E8)
        else $error("applied power above full scale");
endmodule
bind dio_point dio_point_asserts #(.TENTH_CYCLES(TENTH_CYCLES)) u_chk (.ref_clk, .reset,
    .direction, .contact_closed, .voltage_present, .function_block, .field_out,
    .field_out_en, .applied_power);

// ===== verif/dio_load.sv
// far side: mains pulse source and meter of switched load on-time
// assumes the same ref_clk as the point
`timescale 1ns/1ns
module dio_load #(
    parameter int LINE_CLKS = 8
) (
    input  wire logic ref_clk,
    input  wire logic field_out,
    input  wire logic field_out_en,
    output logic      line_cycle,
    output int        on_clks
);
    int ph = 0;
    initial begin
        line_cycle = 1'b0;
        on_clks = 0;
    end
    // mains never stops, so the pulse runs free; load counts only while driven
    always @(posedge ref_clk) begin
        ph <= (ph == LINE_CLKS - 1) ? 0 : ph + 1;
        line_cycle <= (ph == 0);
        on_clks <= on_clks + int'(field_out & field_out_en);
    end
endmodule

// ===== verif/dio_point_test.sv
// bench for the digital i/o point: input modes, forced, fixed and variable bases
// assumes dio_load pulses every 8 clocks; tick shortened to 20 clocks
`timescale 1ns/1ns
module dio_point_test
    import dio_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic [1:0]  direction = 2'h0;
    logic        contact_closed = 1'b0;
    logic        voltage_present = 1'b0;
    dio_demand_s demand = '0;
    logic        demand_is_digital = 1'b0;
    dio_scale_s  limits = {10'h0C8, 10'h258};
    dio_tb_e     time_base = DIO_TB_FIXED;
    logic [9:0]  fixed_period = 10'h001;
    logic        line_cycle, function_block, field_out, field_out_en;
    dio_pct_t    applied_power;
    int          fail_count = 0, cmp_count = 0, on_clks, c0;
    dio_point #(.TENTH_CYCLES(20)) i_dut (.ref_clk, .reset, .direction, .contact_closed,
        .voltage_present, .demand, .demand_is_digital, .limits, .time_base, .fixed_period,
        .line_cycle, .function_block, .field_out, .field_out_en, .applied_power);
    dio_load i_load (.ref_clk, .field_out, .field_out_en, .line_cycle, .on_clks);
    // 100 MHz clock
    initial forever #5 ref_clk = ~ref_clk;
    task automatic tk(int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic chk(string nm, logic [9:0] seen, logic [9:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %0d seen %0d", nm, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic in_case(logic [1:0] d, logic cc, logic vp, logic exp);
        @(posedge ref_clk);
        direction <= d;
        contact_closed <= cc;
        voltage_present <= vp;
        tk(2);
        chk("transmit", 10'(function_block), 10'(exp));
        chk("drive enable", 10'(field_out_en), 10'(d == 2'h2));
    endtask
    // on-time over a window; the period must settle first, so wait one window
    task automatic out_case(logic dig, logic on, dio_pct_t pct, int exp_on, dio_pct_t pw);
        @(posedge ref_clk);
        demand_is_digital <= dig;
        demand <= '{on, pct};
        tk(100);
        c0 = on_clks;
        tk(100);
        chk("held clocks", 10'(on_clks - c0), 10'(exp_on));
        chk("applied power", applied_power, pw);
    endtask
    // bounded wait for a rising output, then count on clocks over n clocks
    task automatic on_time(string nm, int n, int exp);
        int k;
        logic p;
        k = 0;
        p = 1'b1;
        while (!(p === 1'b0 && field_out === 1'b1)) begin
            p = field_out;
            tk(1);
            k++;
            if (k > 3000) begin
                fail_count++;
                finish_test();
            end
        end
        c0 = on_clks;
        tk(n);
        chk(nm, 10'(on_clks - c0), 10'(exp));
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        tk(1);
        chk("out after reset", 10'(field_out), 10'h000);
        in_case(2'h0, 1'b1, 1'b0, 1'b1);
        in_case(2'h0, 1'b0, 1'b1, 1'b0);
        in_case(2'h1, 1'b0, 1'b1, 1'b1);
        in_case(2'h1, 1'b1, 1'b0, 1'b0);
        in_case(2'h3, 1'b1, 1'b1, 1'b0);
        in_case(2'h2, 1'b1, 1'b1, 1'b0);
        out_case(1'b1, 1'b0, 10'h000, 0, 10'h0C8);
        out_case(1'b1, 1'b1, 10'h000, 100, 10'h0C8);
        out_case(1'b0, 1'b0, 10'h000, 0, 10'h0C8);
        out_case(1'b0, 1'b0, 10'h3E8, 100, 10'h258);
        @(posedge ref_clk);
        demand <= '{1'b0, 10'h1F4};
        fixed_period <= 10'h00A;
        tk(450);
        on_time("fixed on clocks", 200, 80);
        chk("scaled power", applied_power, 10'h190);
        @(posedge ref_clk);
        limits <= {10'h000, 10'h3E8};
        time_base <= DIO_TB_VARIABLE;
        tk(300);
        on_time("half on clocks", 48, 24);
        @(posedge ref_clk);
        demand <= '{1'b0, 10'h29B};
        tk(100);
        on_time("two thirds on clocks", 72, 48);
        finish_test();
    end
endmodule
